// [logic/octal_cmd_port.sv]
// device end: serial command and fault port of the octal switch driver
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - serial output driven only while chip select low
// - first sixteen bits out are fault register
// - then input echoed sixteen clocks later
// - sample input on rise, change output on fall
// - words travel least significant bit first
// - top nibble of first word is key 1010
// - mode nibble selects output, diag, protect setting
// - output mode: bit per channel, 1 on
// - diag mode: bit per channel, 1 latching
// - protect mode: bit per channel, 1 limiting
// - valid needs whole words and good key
// - valid transfer clears fault register at end
// - partial word ignored when select rises early
// - only first word reaches the settings
// - reset: all off, non-latching, switch-off, no faults
// - channels 6-8 on by pin or command
// - low reset pin clears all, outputs off
// - two fault bits per channel, channel 1 lowest
// - thermal shutdown at select fall reads all ones
module octal_cmd_port (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link
    spi_link_if.dev link,
    // fault sources from the output stages
    input wire logic [15:0] faultIn,
    input wire logic thermalShutdown,
    // discrete pins
    input wire logic directEnableCh6,
    input wire logic directEnableCh7,
    input wire logic directEnableCh8,
    input wire logic resetPinN,
    // output stage controls
    output logic [7:0] channelOutputs,
    output logic [7:0] faultLatchSelect,
    output logic [7:0] currentProtectSelect
);
    logic [6:0] pinRaw;
    logic [6:0] pinS1_r;
    logic [6:0] pinS2_r;
    logic [6:0] pinS3_r;
    logic [6:0] pinLvl_r;
    logic [6:0] pinLvlD_r;
    logic sclkRise;
    logic sclkFall;
    logic csFall;
    logic csRise;
    logic csLow;
    logic diLvl;
    logic pinResetActive;
    logic [15:0] faultReg_r;
    logic [15:0] outShift_r;
    logic diHeld_r;
    logic [15:0] cmdShift_r;
    logic [3:0] bitCnt_r;
    logic gotFirst_r;
    logic serialOutEn_r;
    logic transferValid;
    logic [7:0] channelOnOffCommand_r;
    logic [7:0] channelFaultLatchSelect_r;
    logic [7:0] channelCurrentProtectSelect_r;
    logic [7:0] channelOutputs_r;

    assign pinRaw = {directEnableCh8, directEnableCh7, directEnableCh6, resetPinN,
                     link.serialIn, link.csN, link.sclk};

    // three-stage sampling of every pin; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinS1_r <= octal_port_pkg::PIN_RST;
            pinS2_r <= octal_port_pkg::PIN_RST;
            pinS3_r <= octal_port_pkg::PIN_RST;
        end else begin
            pinS1_r <= pinRaw;
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinLvl_r <= octal_port_pkg::PIN_RST;
            pinLvlD_r <= octal_port_pkg::PIN_RST;
        end else begin
            pinLvl_r <= (pinS2_r & ~(pinS2_r ^ pinS3_r)) | (pinLvl_r & (pinS2_r ^ pinS3_r));
            pinLvlD_r <= pinLvl_r;
        end
    end

    assign csLow = ~pinLvl_r[1];
    assign csFall = ~pinLvl_r[1] & pinLvlD_r[1];
    assign csRise = pinLvl_r[1] & ~pinLvlD_r[1];
    assign sclkRise = pinLvl_r[0] & ~pinLvlD_r[0] & csLow;
    assign sclkFall = ~pinLvl_r[0] & pinLvlD_r[0] & csLow;
    assign diLvl = pinLvl_r[2];
    assign pinResetActive = ~pinLvl_r[3];

    assign transferValid = gotFirst_r && (bitCnt_r == 4'h0) &&
        (cmdShift_r[octal_port_pkg::KEY_MSB:octal_port_pkg::KEY_LSB] ==
         octal_port_pkg::KEY_WORD);

    // faults collect until a valid transfer ends; a fault in the clearing cycle survives
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            faultReg_r <= octal_port_pkg::FAULT_RST;
        end else if (pinResetActive) begin
            faultReg_r <= octal_port_pkg::FAULT_RST;
        end else if (csRise && transferValid) begin
            faultReg_r <= faultIn;
        end else begin
            faultReg_r <= faultReg_r | faultIn;
        end
    end

    // serial output: fault word first, then the input delayed by one word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outShift_r <= octal_port_pkg::FAULT_RST;
            diHeld_r <= 1'b0;
        end else if (csFall) begin
            outShift_r <= thermalShutdown ? octal_port_pkg::FAULT_THERMAL : faultReg_r;
            diHeld_r <= 1'b0;
        end else begin
            if (sclkRise) begin
                diHeld_r <= diLvl;
            end
            if (sclkFall) begin
                outShift_r <= {diHeld_r, outShift_r[15:1]};
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serialOutEn_r <= 1'b0;
        end else if (csFall) begin
            serialOutEn_r <= 1'b1;
        end else if (csRise) begin
            serialOutEn_r <= 1'b0;
        end
    end

    assign link.serialOut = outShift_r[0];
    assign link.serialOutEn = serialOutEn_r;

    // command capture: only the first word of a frame is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmdShift_r <= 16'h0000;
            bitCnt_r <= 4'h0;
            gotFirst_r <= 1'b0;
        end else if (csFall) begin
            cmdShift_r <= 16'h0000;
            bitCnt_r <= 4'h0;
            gotFirst_r <= 1'b0;
        end else if (sclkRise) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (!gotFirst_r) begin
                cmdShift_r <= {diLvl, cmdShift_r[15:1]};
                if (bitCnt_r == 4'hF) begin
                    gotFirst_r <= 1'b1;
                end
            end
        end
    end

    // settings change only at the end of a valid frame or while the reset pin is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channelOnOffCommand_r <= octal_port_pkg::SETTING_RST;
            channelFaultLatchSelect_r <= octal_port_pkg::SETTING_RST;
            channelCurrentProtectSelect_r <= octal_port_pkg::SETTING_RST;
        end else if (pinResetActive) begin
            channelOnOffCommand_r <= octal_port_pkg::SETTING_RST;
            channelFaultLatchSelect_r <= octal_port_pkg::SETTING_RST;
            channelCurrentProtectSelect_r <= octal_port_pkg::SETTING_RST;
        end else if (csRise && transferValid) begin
            unique case (cmdShift_r[octal_port_pkg::MODE_MSB:octal_port_pkg::MODE_LSB])
                octal_port_pkg::MODE_OUTPUT: channelOnOffCommand_r <= cmdShift_r[7:0];
                octal_port_pkg::MODE_DIAG: channelFaultLatchSelect_r <= cmdShift_r[7:0];
                octal_port_pkg::MODE_PROTECT: begin
                    channelCurrentProtectSelect_r <= cmdShift_r[7:0];
                end
                default: begin
                    channelOnOffCommand_r <= channelOnOffCommand_r;
                end
            endcase
        end
    end

    // pins 6-8 are ORed in after the command; pin low never overrides a set command
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channelOutputs_r <= octal_port_pkg::SETTING_RST;
        end else if (pinResetActive) begin
            channelOutputs_r <= octal_port_pkg::SETTING_RST;
        end else begin
            channelOutputs_r <= channelOnOffCommand_r | {pinLvl_r[6:4], 5'b00000};
        end
    end

    assign channelOutputs = channelOutputs_r;
    assign faultLatchSelect = channelFaultLatchSelect_r;
    assign currentProtectSelect = channelCurrentProtectSelect_r;
endmodule : octal_cmd_port
`default_nettype wire

// [logic/octal_port_pkg.sv]
// shared constants for the octal driver serial command port and its controller
package octal_port_pkg;
    // word layout
    localparam int WORD_BITS = 16;
    localparam int KEY_MSB = 15;
    localparam int KEY_LSB = 12;
    localparam int MODE_MSB = 11;
    localparam int MODE_LSB = 8;
    localparam logic [3:0] KEY_WORD = 4'hA;
    localparam logic [3:0] MODE_OUTPUT = 4'hC;
    localparam logic [3:0] MODE_DIAG = 4'h3;
    localparam logic [3:0] MODE_PROTECT = 4'hA;
    // reset values
    localparam logic [7:0] SETTING_RST = 8'h00;
    localparam logic [15:0] FAULT_RST = 16'h0000;
    localparam logic [15:0] FAULT_THERMAL = 16'hFFFF;
    // pin synchroniser reset: sclk 0, csN 1, serialIn 0, resetPinN 1, enables 0
    localparam logic [6:0] PIN_RST = 7'h0A;
    // timing
    localparam int CLK_NS = 4;
    localparam int SCLK_HALF_NS = 64;
    localparam int CS_LEAD_NS = 455;
    localparam int CS_LAG_NS = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_LEAD_CYC = (CS_LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_LAG_CYC = (CS_LAG_NS + CLK_NS - 1) / CLK_NS;
    // controller register map (APB byte addresses)
    localparam logic [7:0] REG_TX_LO = 8'h00;
    localparam logic [7:0] REG_TX_HI = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RX_LO = 8'h10;
    localparam logic [7:0] REG_RX_HI = 8'h14;
    localparam int CTRL_COUNT_MSB = 5;
    localparam int CTRL_START_BIT = 8;
    localparam logic [5:0] COUNT_RST = 6'h10;
endpackage : octal_port_pkg

// [logic/spi_link_if.sv]
// serial link between the controller and the octal driver port
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
    logic sclk;
    logic csN;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    modport dev (
        input sclk,
        input csN,
        input serialIn,
        output serialOut,
        output serialOutEn
    );
    modport host (
        output sclk,
        output csN,
        output serialIn,
        input serialOut,
        input serialOutEn
    );
endinterface : spi_link_if
`default_nettype wire

// [logic/octal_port_ctrl.sv]
// controller end: APB-programmed serial master for the octal driver port
`timescale 1ns/100ps
`default_nettype none
module octal_port_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link
    spi_link_if.host link
);
    typedef enum logic [4:0] {
        IDLE = 5'b00001,
        LEAD = 5'b00010,
        HIGH = 5'b00100,
        LOW = 5'b01000,
        LAG = 5'b10000
    } link_state_e;

    link_state_e state_r;
    logic [47:0] txData_r;
    logic [47:0] rxData_r;
    logic [5:0] bitCount_r;
    logic [5:0] bitIdx_r;
    logic [7:0] timer_r;
    logic sclk_r;
    logic csN_r;
    logic serialIn_r;
    logic [2:0] doSync_r;
    logic doLvl_r;
    logic apbAccess;
    logic apbWrite;
    logic mapped;
    logic start;
    logic timerDone;

    assign apbAccess = psel & penable;
    assign apbWrite = apbAccess & pwrite;
    assign mapped = (paddr == octal_port_pkg::REG_TX_LO) || (paddr == octal_port_pkg::REG_TX_HI) ||
        (paddr == octal_port_pkg::REG_CTRL) || (paddr == octal_port_pkg::REG_STATUS) ||
        (paddr == octal_port_pkg::REG_RX_LO) || (paddr == octal_port_pkg::REG_RX_HI);
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~mapped;
    assign start = apbWrite && (paddr == octal_port_pkg::REG_CTRL) &&
        pwdata[octal_port_pkg::CTRL_START_BIT] && (state_r == IDLE);
    assign timerDone = (timer_r == 8'h00);

    // register writes are ignored while a frame runs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txData_r <= 48'h000000000000;
            bitCount_r <= octal_port_pkg::COUNT_RST;
        end else if (apbWrite && state_r == IDLE) begin
            if (paddr == octal_port_pkg::REG_TX_LO) txData_r[31:0] <= pwdata;
            if (paddr == octal_port_pkg::REG_TX_HI) txData_r[47:32] <= pwdata[15:0];
            if (paddr == octal_port_pkg::REG_CTRL) begin
                bitCount_r <= pwdata[octal_port_pkg::CTRL_COUNT_MSB:0];
            end
        end
    end

    always_comb begin
        prdata = 32'h00000000;
        if (apbAccess && !pwrite) begin
            unique case (paddr)
                octal_port_pkg::REG_TX_LO: prdata = txData_r[31:0];
                octal_port_pkg::REG_TX_HI: prdata = {16'h0000, txData_r[47:32]};
                octal_port_pkg::REG_CTRL: prdata = {26'h0000000, bitCount_r};
                octal_port_pkg::REG_STATUS: prdata = {31'h00000000, state_r != IDLE};
                octal_port_pkg::REG_RX_LO: prdata = rxData_r[31:0];
                octal_port_pkg::REG_RX_HI: prdata = {16'h0000, rxData_r[47:32]};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // returned data from the far clock domain; level taken when stages agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doSync_r <= 3'b000;
            doLvl_r <= 1'b0;
        end else begin
            doSync_r <= {doSync_r[1:0], link.serialOut};
            if (doSync_r[1] == doSync_r[2]) doLvl_r <= doSync_r[2];
        end
    end

    // frame sequencer; sclk idles low and is divided from clk
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= IDLE;
            timer_r <= 8'h00;
            bitIdx_r <= 6'h00;
            sclk_r <= 1'b0;
            csN_r <= 1'b1;
            serialIn_r <= 1'b0;
            rxData_r <= 48'h000000000000;
        end else begin
            if (!timerDone) timer_r <= timer_r - 8'h01;
            unique case (state_r)
                IDLE: if (start) begin
                    csN_r <= 1'b0;
                    serialIn_r <= txData_r[0];
                    bitIdx_r <= 6'h00;
                    rxData_r <= 48'h000000000000;
                    timer_r <= 8'(octal_port_pkg::CS_LEAD_CYC);
                    state_r <= LEAD;
                end
                LEAD, LOW: if (timerDone) begin
                    sclk_r <= 1'b1;
                    rxData_r[bitIdx_r] <= doLvl_r;
                    timer_r <= 8'(octal_port_pkg::SCLK_HALF_CYC);
                    state_r <= HIGH;
                end
                HIGH: if (timerDone) begin
                    sclk_r <= 1'b0;
                    timer_r <= 8'(octal_port_pkg::SCLK_HALF_CYC);
                    // counts above 48 stop at the last buffered bit
                    if ((bitIdx_r + 6'h01 >= bitCount_r) || (bitIdx_r == 6'h2F)) begin
                        timer_r <= 8'(octal_port_pkg::CS_LAG_CYC);
                        state_r <= LAG;
                    end else begin
                        bitIdx_r <= bitIdx_r + 6'h01;
                        serialIn_r <= txData_r[bitIdx_r + 6'h01];
                        state_r <= LOW;
                    end
                end
                LAG: if (timerDone) begin
                    csN_r <= 1'b1;
                    state_r <= IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.csN = csN_r;
    assign link.serialIn = serialIn_r;
endmodule : octal_port_ctrl
`default_nettype wire

// [tb/octal_port_properties.sv]
// link assertions between the serial controller and the octal driver port
`timescale 1ns/100ps
`default_nettype none
module octal_port_properties (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link
    input wire logic sclk,
    input wire logic csN,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // pin samplers add 3-4 cycles, so windows allow up to 8
    a_out_idle_off: assert property (csN [*8] |-> !serialOutEn)
        else $error("data out driven while deselected");
    a_out_on_select: assert property ($fell(csN) |-> ##[2:8] serialOutEn)
        else $error("data out not driven after select");
    a_out_drop: assert property ($rose(csN) |-> ##[2:8] !serialOutEn)
        else $error("data out not released after deselect");
    a_sclk_idle_low: assert property (csN |-> !sclk)
        else $error("serial clock active while deselected");
    a_select_lead: assert property ($fell(csN) |-> !sclk [*8])
        else $error("serial clock too soon after select");
    a_select_lag: assert property ($rose(csN) |-> !$past(sclk) && !$past(sclk, 8))
        else $error("deselect too soon after serial clock");
    a_din_held: assert property ($rose(sclk) |-> $stable(serialIn) ##1 $stable(serialIn))
        else $error("data in moved around sampling edge");
    a_dout_on_fall: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut)
        |-> !sclk && $past(sclk, 8))
        else $error("data out changed away from falling clock");

    c_select: cover property ($fell(csN));
    c_clocked: cover property ($rose(sclk) && !csN);
    c_out_high: cover property (serialOutEn && serialOut);
endmodule : octal_port_properties
`default_nettype wire

// [tb/octal_cmd_port_tb.sv]
// self-checking bench: APB controller commands the octal driver port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module octal_cmd_port_tb;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, lastErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic [15:0] faultIn;
    logic thermalShutdown, resetPinN;
    logic [2:0] directEn;
    logic [7:0] chOut, latchSel, protSel;
    logic [47:0] rxd;
    int num_errors, n_tests;

    spi_link_if link();
    // board level of the data out line; floats while released
    wire doLine;
    assign doLine = link.serialOutEn ? link.serialOut : 1'bz;
    octal_port_ctrl octal_port_ctrl_inst (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    octal_cmd_port octal_cmd_port_inst (.clk(clk), .resetn(resetn), .link(link.dev),
        .faultIn(faultIn), .thermalShutdown(thermalShutdown), .directEnableCh6(directEn[0]),
        .directEnableCh7(directEn[1]), .directEnableCh8(directEn[2]), .resetPinN(resetPinN),
        .channelOutputs(chOut), .faultLatchSelect(latchSel), .currentProtectSelect(protSel));
    octal_port_properties octal_port_properties_inst (.clk(clk), .resetn(resetn),
        .sclk(link.sclk), .csN(link.csN), .serialIn(link.serialIn),
        .serialOut(link.serialOut), .serialOutEn(link.serialOutEn));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        rdData = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 64) begin
            num_errors++;
            $display("[ERR] %0t bus access timed out", $time);
            give_verdict();
        end
    endtask : apb

    // bits leave lsb first; rx holds what came back in the same layout
    task automatic frame(input logic [47:0] tx, input logic [5:0] cnt);
        int k;
        apb(octal_port_pkg::REG_TX_LO, 1'b1, tx[31:0]);
        apb(octal_port_pkg::REG_TX_HI, 1'b1, {16'h0000, tx[47:32]});
        apb(octal_port_pkg::REG_CTRL, 1'b1, {23'h000000, 1'b1, 2'h0, cnt});
        k = 0;
        do begin
            apb(octal_port_pkg::REG_STATUS, 1'b0, 32'h00000000);
            k++;
        end while (rdData[0] !== 1'b0 && k < 1000);
        if (k >= 1000) begin
            num_errors++;
            $display("[ERR] %0t frame never finished", $time);
            give_verdict();
        end
        apb(octal_port_pkg::REG_RX_LO, 1'b0, 32'h00000000);
        rxd[31:0] = rdData;
        apb(octal_port_pkg::REG_RX_HI, 1'b0, 32'h00000000);
        rxd[47:32] = rdData[15:0];
        // device sees the deselect through its pin samplers
        repeat (8) @(posedge clk);
    endtask : frame

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        faultIn = 16'h1B4E;
        thermalShutdown = 1'b0;
        directEn = 3'h0;
        resetPinN = 1'b1;
        num_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        frame(48'h0000_0000_5CFF, 6'h10);
        `CHK(rxd[15:0], 16'h1B4E)
        `CHK({chOut, latchSel, protSel}, 24'h000000)
        faultIn <= 16'h0000;
        $display("test bad key done");
        frame(48'h0000_A3FF_AC5A, 6'h20);
        `CHK(rxd[31:0], 32'hAC5A_1B4E)
        `CHK(chOut, 8'h5A)
        `CHK(latchSel, 8'h00)
        frame(48'h0000_0000_A3C3, 6'h10);
        `CHK(rxd[15:0], 16'h0000)
        `CHK(latchSel, 8'hC3)
        frame(48'hABCD_1234_AA96, 6'h30);
        `CHK(rxd, 48'h1234_AA96_0000)
        `CHK(protSel, 8'h96)
        $display("test modes done");
        faultIn <= 16'h00C0;
        repeat (4) @(posedge clk);
        faultIn <= 16'h0000;
        for (int i = 0; i < 2; i++) begin
            frame(48'h0000_0000_AC00, (i == 0) ? 6'h0C : 6'h18);
            `CHK(chOut, 8'h5A)
        end
        frame(48'h0000_0000_AFFF, 6'h10);
        `CHK(rxd[15:0], 16'h00C0)
        `CHK({chOut, latchSel, protSel}, 24'h5AC396)
        $display("test partial done");
        thermalShutdown <= 1'b1;
        frame(48'h0000_0000_AF00, 6'h10);
        `CHK(rxd[15:0], 16'hFFFF)
        thermalShutdown <= 1'b0;
        directEn <= 3'h7;
        repeat (10) @(posedge clk);
        `CHK(chOut, 8'hFA)
        directEn <= 3'h0;
        repeat (10) @(posedge clk);
        `CHK(chOut, 8'h5A)
        resetPinN <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK({chOut, latchSel, protSel}, 24'h000000)
        resetPinN <= 1'b1;
        `CHK(doLine, 1'bz)
        apb(8'h20, 1'b0, 32'h00000000);
        `CHK(rdData, 32'h00000000)
        `CHK(lastErr, 1'b1)
        $display("test pins done");
        give_verdict();
    end
endmodule : octal_cmd_port_tb
`default_nettype wire
